// [rtta_top.sv]
// Tick, alarm flag and wake-up logic of the real-time clock
// Function
// - With the tick interrupt enable set, each tick period sets the tick flag.
// - Writing one to the tick flag clears it, writing zero leaves it.
// - With the alarm interrupt enable set, a time and calendar match sets the alarm flag.
// - Writing one to the alarm flag clears it, writing zero leaves it.
// - Each source requests an interrupt only in the cycle after its flag and its enable were both one.
// - The three-bit select gives a tick period of one second over two to its value.
// - With wake-up enabled in power-down, every tick raises a wake-up request.
// - With wake-up enabled an alarm match also wakes, with it cleared nothing wakes.
// - The enable register holds tick enable at bit 1 and alarm enable at bit 0.
// - Settings read back only once the access enable flag is active.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module rtta_top #(
  parameter int SEL_W     = 3,
  parameter int BASE_LOG2 = 7
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        base_128hz_i,
  input  wire logic [31:0] time_counter_i,
  input  wire logic [31:0] calendar_counter_i,
  input  wire logic [31:0] alarm_time_setting_i,
  input  wire logic [31:0] alarm_calendar_setting_i,
  input  wire logic        access_enable_flag_i,
  input  wire logic        power_down_i,
  output logic             tick_irq_o,
  output logic             alarm_irq_o,
  output logic             irq_o,
  output logic             wakeup_o
);

  if (SEL_W != rtta_pkg::SEL_W || BASE_LOG2 != (1 << SEL_W) - 1 ||
      (1 << BASE_LOG2) != rtta_pkg::BASE_HZ) begin : g_bad_params
    $error("rtta_top: select width and base divider do not match");
  end

  // Register state
  logic                 tick_irq_enable;
  logic                 alarm_irq_enable;
  logic                 tick_flag;
  logic                 alarm_flag;
  logic [SEL_W-1:0]     tick_period_select;
  logic                 wakeup_enable;
  logic [BASE_LOG2-1:0] base_cnt;
  logic                 match_d;

  // Decode and event terms
  logic wr_enables;
  logic wr_flags;
  logic wr_tick;
  logic tick_evt;
  logic alarm_match;
  logic alarm_evt;
  logic next_tick_flag;
  logic next_alarm_flag;

  // Tick falls on a base pulse once the unmasked low count bits are all ones
  function automatic logic tick_due(input logic [BASE_LOG2-1:0] cnt,
                                    input logic [SEL_W-1:0]     sel);
    logic [BASE_LOG2-1:0] mask;
    mask = '1;
    mask = mask << (BASE_LOG2[SEL_W:0] - {1'b0, sel});
    return &(cnt | mask);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign wr_enables = wr_i && hit(addr_i, rtta_pkg::ENABLES_OFS);
  assign wr_flags   = wr_i && hit(addr_i, rtta_pkg::FLAGS_OFS);
  assign wr_tick    = wr_i && hit(addr_i, rtta_pkg::TICK_OFS);

  // Divider of the one-second time base
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_cnt <= '0;
    end else if (base_128hz_i) begin
      base_cnt <= base_cnt + 1'b1;
    end
  end

  assign tick_evt = base_128hz_i && tick_due(base_cnt, tick_period_select);

  // Alarm match edge, so a standing match sets the flag once
  assign alarm_match = (time_counter_i == alarm_time_setting_i) &&
                       (calendar_counter_i == alarm_calendar_setting_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_d <= 1'b0;
    end else begin
      match_d <= alarm_match;
    end
  end

  assign alarm_evt = alarm_match && !match_d;

  // Enable register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_irq_enable  <= rtta_pkg::ENABLES_RST[rtta_pkg::TICK_BIT];
      alarm_irq_enable <= rtta_pkg::ENABLES_RST[rtta_pkg::ALARM_BIT];
    end else if (wr_enables) begin
      tick_irq_enable  <= wdata_i[rtta_pkg::TICK_BIT];
      alarm_irq_enable <= wdata_i[rtta_pkg::ALARM_BIT];
    end
  end

  // Tick period and wake-up register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_period_select <= rtta_pkg::SEL_RST;
      wakeup_enable      <= rtta_pkg::WAKE_RST;
    end else if (wr_tick) begin
      tick_period_select <= wdata_i[rtta_pkg::SEL_LSB +: SEL_W];
      wakeup_enable      <= wdata_i[rtta_pkg::WAKE_BIT];
    end
  end

  // Flags: a new event wins over a clear in the same cycle
  always_comb begin
    next_tick_flag  = tick_flag;
    next_alarm_flag = alarm_flag;
    if (wr_flags && wdata_i[rtta_pkg::TICK_BIT]) begin
      next_tick_flag = 1'b0;
    end
    if (wr_flags && wdata_i[rtta_pkg::ALARM_BIT]) begin
      next_alarm_flag = 1'b0;
    end
    if (tick_evt && tick_irq_enable) begin
      next_tick_flag = 1'b1;
    end
    if (alarm_evt && alarm_irq_enable) begin
      next_alarm_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_flag  <= rtta_pkg::FLAGS_RST[rtta_pkg::TICK_BIT];
      alarm_flag <= rtta_pkg::FLAGS_RST[rtta_pkg::ALARM_BIT];
    end else begin
      tick_flag  <= next_tick_flag;
      alarm_flag <= next_alarm_flag;
    end
  end

  // Interrupt requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_irq_o  <= 1'b0;
      alarm_irq_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      tick_irq_o  <= tick_flag && tick_irq_enable;
      alarm_irq_o <= alarm_flag && alarm_irq_enable;
      irq_o       <= (tick_flag && tick_irq_enable) ||
                     (alarm_flag && alarm_irq_enable);
    end
  end

  // Wake-up request from power-down
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wakeup_o <= 1'b0;
    end else begin
      wakeup_o <= power_down_i && wakeup_enable && (tick_evt || alarm_evt);
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      if (hit(addr_i, rtta_pkg::FLAGS_OFS)) begin
        rdata_o[rtta_pkg::TICK_BIT]  <= tick_flag;
        rdata_o[rtta_pkg::ALARM_BIT] <= alarm_flag;
      end else if (hit(addr_i, rtta_pkg::ENABLES_OFS) && access_enable_flag_i) begin
        rdata_o[rtta_pkg::TICK_BIT]  <= tick_irq_enable;
        rdata_o[rtta_pkg::ALARM_BIT] <= alarm_irq_enable;
      end else if (hit(addr_i, rtta_pkg::TICK_OFS) && access_enable_flag_i) begin
        rdata_o[rtta_pkg::SEL_LSB +: SEL_W] <= tick_period_select;
        rdata_o[rtta_pkg::WAKE_BIT]         <= wakeup_enable;
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // Checks
  sequence s_tick_set;
    tick_evt && tick_irq_enable;
  endsequence

  sequence s_alarm_set;
    alarm_evt && alarm_irq_enable;
  endsequence

  sequence s_wake_cause;
    power_down_i && wakeup_enable && (tick_evt || alarm_evt);
  endsequence

  a_tick_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_tick_set |=> tick_flag ##1 (tick_irq_o || !tick_irq_enable))
    else $error("tick flag not set by tick");

  a_tick_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_flags && wdata_i[rtta_pkg::TICK_BIT] && !(tick_evt && tick_irq_enable)) |=> !tick_flag)
    else $error("tick flag not cleared by write one");

  a_tick_flag_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick_flag && !(wr_flags && wdata_i[rtta_pkg::TICK_BIT])) |=> tick_flag)
    else $error("tick flag lost without write one");

  a_alarm_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_alarm_set |=> alarm_flag)
    else $error("alarm flag not set by match");

  a_alarm_flag_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alarm_match && match_d && !alarm_flag) |=> !alarm_flag)
    else $error("alarm flag set by standing match");

  a_alarm_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_flags && wdata_i[rtta_pkg::ALARM_BIT] && !(alarm_evt && alarm_irq_enable)) |=>
      !alarm_flag)
    else $error("alarm flag not cleared by write one");

  a_irq_gate_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 irq_o == ($past(tick_flag && tick_irq_enable) || $past(alarm_flag && alarm_irq_enable)))
    else $error("interrupt request not gated by flag and enable");

  a_tick_on_base: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_evt |-> base_128hz_i &&
      (tick_period_select != '0 || base_cnt == '1))
    else $error("tick outside its period");

  a_tick_fastest: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (base_128hz_i && tick_period_select == '1) |-> tick_evt)
    else $error("fastest tick missed a base pulse");

  a_wake_tick_evt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_cause |=> wakeup_o)
    else $error("wake-up not raised in power-down");

  a_wake_off_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wakeup_enable |=> !wakeup_o)
    else $error("wake-up raised while disabled");

  a_read_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && !access_enable_flag_i && hit(addr_i, rtta_pkg::TICK_OFS)) |=> rdata_o == '0)
    else $error("settings read before access enabled");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rdata_o[31:rtta_pkg::WAKE_BIT+1] == '0)
    else $error("reserved bits read nonzero");

  a_tick_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!tick_flag && !(tick_evt && tick_irq_enable)) |=> !tick_flag)
    else $error("tick flag set without enabled tick");

  a_alarm_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!alarm_flag && !(alarm_evt && alarm_irq_enable)) |=> !alarm_flag)
    else $error("alarm flag set without enabled match");

  a_alarm_flag_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alarm_flag && !(wr_flags && wdata_i[rtta_pkg::ALARM_BIT])) |=> alarm_flag)
    else $error("alarm flag lost without write one");

  a_tick_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 tick_irq_o == $past(tick_flag && tick_irq_enable))
    else $error("tick request not gated by flag and enable");

  a_alarm_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 alarm_irq_o == $past(alarm_flag && alarm_irq_enable))
    else $error("alarm request not gated by flag and enable");

  a_wake_awake_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !power_down_i |=> !wakeup_o)
    else $error("wake-up raised outside power-down");

  a_wake_alarm_evt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (power_down_i && wakeup_enable && alarm_evt) |=> wakeup_o)
    else $error("wake-up not raised by alarm match");

  a_read_flags_now: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && hit(addr_i, rtta_pkg::FLAGS_OFS)) |=>
      (rdata_o[rtta_pkg::TICK_BIT] == $past(tick_flag) &&
       rdata_o[rtta_pkg::ALARM_BIT] == $past(alarm_flag)))
    else $error("flag read does not show the flags");

  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data not zero outside read");

  a_base_cnt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !base_128hz_i |=> $stable(base_cnt))
    else $error("divider moved without base pulse");

endmodule // rtta_top

// [rtta_pkg.sv]
// Constants shared by the tick, alarm and wake-up logic
package rtta_pkg;
  // Register byte offsets
  localparam logic [7:0] ENABLES_OFS = 8'h28;
  localparam logic [7:0] FLAGS_OFS   = 8'h2C;
  localparam logic [7:0] TICK_OFS    = 8'h30;

  // Field positions
  localparam int ALARM_BIT   = 0;
  localparam int TICK_BIT    = 1;
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 3;
  localparam int WAKE_BIT    = 3;

  // Reset values
  localparam logic [1:0] ENABLES_RST = 2'h0;
  localparam logic [1:0] FLAGS_RST   = 2'h0;
  localparam logic [2:0] SEL_RST     = 3'h0;
  localparam logic       WAKE_RST    = 1'h0;

  // Base rate of the incoming time base pulse, in Hz
  localparam int BASE_HZ     = 128;
  // Clock rate
  localparam int CLK_HZ      = 125_000_000;
endpackage : rtta_pkg

// [rtta_tb.sv]
// Self-checking testbench for the tick, alarm and wake-up block
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        base_128hz_i = 1'b0;
  logic [31:0] time_counter_i = 32'h0;
  logic [31:0] calendar_counter_i = 32'h0;
  logic [31:0] alarm_time_setting_i = 32'h1;
  logic [31:0] alarm_calendar_setting_i = 32'h0;
  logic        access_enable_flag_i = 1'b1;
  logic        power_down_i = 1'b0;
  logic        tick_irq_o;
  logic        alarm_irq_o;
  logic        irq_o;
  logic        wakeup_o;
  logic        rd_q = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [31:0] r;
  int          errors = 0;
  int          samples_checked = 0;
  int          wake_cnt = 0;
  int          seen;
  int          w0;

  rtta_top u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .base_128hz_i,
    .time_counter_i, .calendar_counter_i, .alarm_time_setting_i, .alarm_calendar_setting_i,
    .access_enable_flag_i, .power_down_i, .tick_irq_o, .alarm_irq_o, .irq_o, .wakeup_o);

  always #4 clk_i = ~clk_i;

  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(x);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // One base pulse, returns once the irq outputs have followed it
  task automatic pulse;
    @(posedge clk_i);
    base_128hz_i <= 1'b1;
    @(posedge clk_i);
    base_128hz_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(rdata_o, e)
    end
    rd_q <= rd_i;
    if (wakeup_o === 1'b1) wake_cnt++;
  end

  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  initial begin
    r = $urandom(32'h13DE29CA);
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(rtta_pkg::FLAGS_OFS, 32'h0);
    rd(rtta_pkg::ENABLES_OFS, 32'h0);
    rd(rtta_pkg::TICK_OFS, 32'h0);
    rd(8'h34, 32'h0);
    wr(rtta_pkg::ENABLES_OFS, 32'hFFFFFFFF);
    rd(rtta_pkg::ENABLES_OFS, 32'h3);
    wr(rtta_pkg::TICK_OFS, 32'hFFFFFFF7);
    rd(rtta_pkg::TICK_OFS, 32'h7);
    access_enable_flag_i <= 1'b0;
    rd(rtta_pkg::TICK_OFS, 32'h0);
    rd(rtta_pkg::ENABLES_OFS, 32'h0);
    rd(rtta_pkg::FLAGS_OFS, 32'h0);
    access_enable_flag_i <= 1'b1;
    power_down_i <= 1'b1;
    // Every select over 128 base pulses, wake-up on odd selects
    for (int s = 0; s < 8; s++) begin
      wr(rtta_pkg::TICK_OFS, {28'h0, s[0], s[2:0]});
      seen = 0;
      w0 = wake_cnt;
      repeat (128) begin
        repeat ($urandom_range(3)) @(posedge clk_i);
        pulse();
        if (tick_irq_o === 1'b1) begin
          seen++;
          wr(rtta_pkg::FLAGS_OFS, 32'h2);
        end
      end
      `CHK(seen, 1 << s)
      `CHK(wake_cnt - w0, s[0] ? (1 << s) : 0)
    end
    pulse();
    wr(rtta_pkg::ENABLES_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(tick_irq_o, 1'b0)
    `CHK(irq_o, 1'b0)
    wr(rtta_pkg::FLAGS_OFS, 32'h0);
    rd(rtta_pkg::FLAGS_OFS, 32'h2);
    wr(rtta_pkg::FLAGS_OFS, 32'h2);
    pulse();
    rd(rtta_pkg::FLAGS_OFS, 32'h0);
    wr(rtta_pkg::ENABLES_OFS, 32'h3);
    w0 = wake_cnt;
    r = $urandom();
    time_counter_i <= r;
    alarm_time_setting_i <= r;
    calendar_counter_i <= ~r;
    alarm_calendar_setting_i <= ~r;
    repeat (3) @(posedge clk_i);
    `CHK(alarm_irq_o, 1'b1)
    `CHK(irq_o, 1'b1)
    `CHK(wake_cnt - w0, 1)
    wr(rtta_pkg::FLAGS_OFS, 32'h0);
    rd(rtta_pkg::FLAGS_OFS, 32'h1);
    wr(rtta_pkg::FLAGS_OFS, 32'h1);
    rd(rtta_pkg::FLAGS_OFS, 32'h0);
    `CHK(alarm_irq_o, 1'b0)
    wr(rtta_pkg::ENABLES_OFS, 32'h2);
    time_counter_i <= r ^ 32'h1;
    @(posedge clk_i);
    time_counter_i <= r;
    repeat (3) @(posedge clk_i);
    rd(rtta_pkg::FLAGS_OFS, 32'h0);
    power_down_i <= 1'b0;
    w0 = wake_cnt;
    pulse();
    `CHK(wake_cnt - w0, 0)
    repeat (2) @(posedge clk_i);
    give_verdict();
  end
endmodule // tb
